//--- core/doms_pkg.sv
// Contract
// - interlock on: no panel entry with start
// - value 7 makes output-stop the interlock
// - output-stop logic 2 inverts interlock polarity
// - panel/external switching only while stopped; code also switches while running for value 6
// - panel/external switch honoured for 0,6,7
// - terminal code 16 assigns panel/external switch
// - mode-select table under panel/external switch
// - value 7: interlock off forces external
// - precedence select, interlock, net/ext, net/panel
// - network switches change mode only when stopped; code also does for value 6, and leaves network at once for 2
// - net/panel switch on panel, off network
// - startup 10 never selects external for 0/6
// - startup 10: 1 panel, 2 network fixed
// - startup 10, value 7 follows interlock
// - net/panel results refined by other inputs
// - startup 10, value 7, switch on: external
// - net/ext switch on network, off external
// - net/ext table for values 1, 2, 7; code ignores it for 1 and also applies it for 0 and 6
// - external result refined by other switches
// - mode-select accepts 0-4,6,7, resets 0
package doms_pkg;
  localparam logic [2:0] MSEL_RESET = 3'h0;
  localparam logic [2:0] MSEL_FREE = 3'h0;
  localparam logic [2:0] MSEL_PANEL = 3'h1;
  localparam logic [2:0] MSEL_EXT = 3'h2;
  localparam logic [2:0] MSEL_COMB3 = 3'h3;
  localparam logic [2:0] MSEL_COMB4 = 3'h4;
  localparam logic [2:0] MSEL_RUNSW = 3'h6;
  localparam logic [2:0] MSEL_LOCK = 3'h7;
  localparam logic [3:0] START_NET_PANEL = 4'ha;
  localparam logic [1:0] STOP_LOGIC_INV = 2'h2;
  localparam logic [6:0] CODE_PE_SW = 7'h10;
  localparam logic [6:0] CODE_NP_SW = 7'h41;
  localparam logic [6:0] CODE_NE_SW = 7'h42;
  localparam logic [6:0] CODE_LOCK = 7'h0c;
  localparam int N_TERM = 7;
  localparam logic [3:0] MODE_RESET = 4'h2;

  typedef enum logic [1:0] {
    DOMS_PANEL, DOMS_EXT, DOMS_NET, DOMS_COMB
  } doms_mode_t;

  typedef struct packed {
    logic [2:0] mode_select;
    logic [3:0] startup_mode;
    logic [1:0] stop_logic;
    logic net_src_zero;
    logic option_fitted;
  } doms_cfg_t;

  typedef struct packed {
    logic interlock;
    logic output_stop;
    logic fwd;
    logic rev;
    logic pe_sw;
    logic np_sw;
    logic ne_sw;
    logic at_rest;
  } doms_in_t;
endpackage

//--- core/doms_mode_selector.sv
`timescale 1ns/1ps
module doms_mode_selector #(
  parameter int N_TERM = doms_pkg::N_TERM
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // settings
  input wire doms_pkg::doms_cfg_t i_cfg,
  input wire logic i_cfg_we,
  input wire logic [6:0] i_term_func [N_TERM],
  // pins and drive state
  input wire doms_pkg::doms_in_t i_pins,
  // results
  output logic [3:0] o_mode_onehot,
  output logic o_output_stop,
  output logic o_interlock_active,
  output logic [2:0] o_mode_select
);
  doms_pkg::doms_cfg_t cfg_r;
  doms_pkg::doms_in_t s1_r, s2_r, s3_r, in_r;
  logic [3:0] mode_r, mode_nxt;
  logic as_pe, as_np, as_ne, as_lock;
  logic [N_TERM-1:0] hit_pe, hit_np, hit_ne, hit_lock;
  logic valid_sel, stopped, lock_raw, lock_on, free_sw, run_ok;
  doms_pkg::doms_mode_t want, cur;

  // terminal assignment decode
  genvar g;
  for (g = 0; g < N_TERM; g++) begin : g_term
    assign hit_pe[g] = (i_term_func[g] == doms_pkg::CODE_PE_SW);
    assign hit_np[g] = (i_term_func[g] == doms_pkg::CODE_NP_SW);
    assign hit_ne[g] = (i_term_func[g] == doms_pkg::CODE_NE_SW);
    assign hit_lock[g] = (i_term_func[g] == doms_pkg::CODE_LOCK);
  end
  assign as_pe = |hit_pe;
  assign as_np = |hit_np;
  assign as_ne = |hit_ne;
  assign as_lock = |hit_lock;

  always_comb begin
    unique case (i_cfg.mode_select)
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7: valid_sel = 1'b1;
      default: valid_sel = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cfg_r <= '0;
      cfg_r.mode_select <= doms_pkg::MSEL_RESET;
    end else if (i_cfg_we) begin
      cfg_r.startup_mode <= i_cfg.startup_mode;
      cfg_r.stop_logic <= i_cfg.stop_logic;
      cfg_r.net_src_zero <= i_cfg.net_src_zero;
      cfg_r.option_fitted <= i_cfg.option_fitted;
      if (valid_sel) begin
        cfg_r.mode_select <= i_cfg.mode_select;
      end
    end
  end

  // three-stage pin synchroniser, change taken when stages 2 and 3 agree
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      in_r <= '0;
    end else begin
      s1_r <= i_pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int k = 0; k < 8; k++) begin
        if (s2_r[k] == s3_r[k]) begin
          in_r[k] <= s3_r[k];
        end
      end
    end
  end

  // interlock source: own terminal, else the output-stop pin
  always_comb begin
    if (as_lock) begin
      lock_raw = in_r.interlock;
    end else begin
      lock_raw = in_r.output_stop ^
                 (cfg_r.stop_logic == doms_pkg::STOP_LOGIC_INV);
    end
  end
  assign lock_on = lock_raw;
  // value 7 turns the output-stop pin into the interlock at once
  assign o_interlock_active = (cfg_r.mode_select == doms_pkg::MSEL_LOCK);

  assign stopped = in_r.at_rest & ~in_r.fwd & ~in_r.rev;
  assign free_sw = (cfg_r.mode_select == doms_pkg::MSEL_FREE) |
                   (cfg_r.mode_select == doms_pkg::MSEL_RUNSW) |
                   (cfg_r.mode_select == doms_pkg::MSEL_LOCK);
  assign run_ok = stopped |
                  (cfg_r.mode_select == doms_pkg::MSEL_RUNSW);

  always_comb begin
    unique case (mode_r)
      4'h1: cur = doms_pkg::DOMS_PANEL;
      4'h4: cur = doms_pkg::DOMS_NET;
      4'h8: cur = doms_pkg::DOMS_COMB;
      default: cur = doms_pkg::DOMS_EXT;
    endcase
  end

  // precedence: select, interlock, net/ext, net/panel, panel/ext, else current mode held
  always_comb begin
    logic pe_ext;
    logic np_off_pan;
    pe_ext = as_pe ? in_r.pe_sw : 1'b1;
    np_off_pan = (as_pe & ~in_r.pe_sw) |
                 (cfg_r.net_src_zero & ~cfg_r.option_fitted);
    want = cur;
    unique case (cfg_r.mode_select)
      doms_pkg::MSEL_PANEL: want = doms_pkg::DOMS_PANEL;
      doms_pkg::MSEL_COMB3,
      doms_pkg::MSEL_COMB4: want = doms_pkg::DOMS_COMB;
      doms_pkg::MSEL_EXT: begin
        if (cfg_r.startup_mode == doms_pkg::START_NET_PANEL) begin
          want = doms_pkg::DOMS_NET;
        end else if (as_ne) begin
          want = in_r.ne_sw ? doms_pkg::DOMS_NET : doms_pkg::DOMS_EXT;
        end else begin
          want = doms_pkg::DOMS_EXT;
        end
      end
      default: begin
        if (cfg_r.mode_select == doms_pkg::MSEL_LOCK && !lock_on) begin
          want = doms_pkg::DOMS_EXT;
        end else if (as_ne && in_r.ne_sw) begin
          want = doms_pkg::DOMS_NET;
        end else if (cfg_r.startup_mode == doms_pkg::START_NET_PANEL &&
                     as_np) begin
          if (cfg_r.mode_select == doms_pkg::MSEL_LOCK) begin
            want = pe_ext ? doms_pkg::DOMS_EXT : doms_pkg::DOMS_PANEL;
          end else if (in_r.np_sw) begin
            want = doms_pkg::DOMS_PANEL;
          end else begin
            want = np_off_pan ? doms_pkg::DOMS_PANEL :
                   doms_pkg::DOMS_NET;
          end
        end else if (as_ne) begin
          if (as_np) begin
            want = in_r.np_sw ? doms_pkg::DOMS_PANEL :
                   doms_pkg::DOMS_NET;
          end else begin
            want = (as_pe & ~in_r.pe_sw) ? doms_pkg::DOMS_PANEL :
                   doms_pkg::DOMS_EXT;
          end
        end else if (as_pe && free_sw) begin
          want = in_r.pe_sw ? doms_pkg::DOMS_EXT :
                 doms_pkg::DOMS_PANEL;
        end
      end
    endcase
  end

  always_comb begin
    mode_nxt = mode_r;
    if (want != cur) begin
      if (cfg_r.mode_select == doms_pkg::MSEL_LOCK && !lock_on) begin
        mode_nxt = 4'h2; // forced regardless of start
      end else if (cfg_r.mode_select == doms_pkg::MSEL_PANEL ||
                   cfg_r.mode_select == doms_pkg::MSEL_COMB3 ||
                   cfg_r.mode_select == doms_pkg::MSEL_COMB4 ||
                   (cfg_r.mode_select == doms_pkg::MSEL_EXT &&
                    (want != doms_pkg::DOMS_NET ||
                     cfg_r.startup_mode == doms_pkg::START_NET_PANEL))) begin
        mode_nxt = 4'h1 << want;
      end else if (run_ok) begin
        if (!(want == doms_pkg::DOMS_PANEL && lock_on &&
              (in_r.fwd | in_r.rev) &&
              cfg_r.mode_select == doms_pkg::MSEL_LOCK)) begin
          mode_nxt = 4'h1 << want;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mode_r <= doms_pkg::MODE_RESET;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_output_stop <= 1'b0;
    end else begin
      o_output_stop <= (cfg_r.mode_select == doms_pkg::MSEL_LOCK) ?
                       (lock_on & (mode_nxt == 4'h2)) :
                       in_r.output_stop;
    end
  end

  assign o_mode_onehot = mode_r;
  assign o_mode_select = cfg_r.mode_select;

  a_onehot_mode: assert property (@(posedge i_mclk)
    disable iff (i_rst) $onehot(mode_r))
    else $error("mode not one-hot");
  a_panel_fixed: assert property (@(posedge i_mclk)
    disable iff (i_rst) cfg_r.mode_select == 3'h1 |=> mode_r == 4'h1)
    else $error("panel not fixed");
  a_comb_fixed: assert property (@(posedge i_mclk)
    disable iff (i_rst)
    (cfg_r.mode_select == 3'h3 || cfg_r.mode_select == 3'h4) |=>
    mode_r == 4'h8) else $error("combined not fixed");
  a_lock_force: assert property (@(posedge i_mclk)
    disable iff (i_rst) cfg_r.mode_select == 3'h7 && !lock_on |=>
    mode_r == 4'h2) else $error("interlock off not external");
  a_run_hold: assert property (@(posedge i_mclk)
    disable iff (i_rst) !stopped && cfg_r.mode_select == 3'h0 |=>
    $stable(mode_r)) else $error("switch while running");
  a_sel_legal: assert property (@(posedge i_mclk)
    disable iff (i_rst) cfg_r.mode_select != 3'h5)
    else $error("illegal select");
  a_no_panel_start: assert property (@(posedge i_mclk)
    disable iff (i_rst) lock_on && (in_r.fwd || in_r.rev) &&
    mode_r != 4'h1 && cfg_r.mode_select == 3'h7 |=> mode_r != 4'h1)
    else $error("panel entered with start");
  a_net_fix10: assert property (@(posedge i_mclk)
    disable iff (i_rst) cfg_r.mode_select == 3'h2 &&
    cfg_r.startup_mode == 4'ha |=> mode_r == 4'h4)
    else $error("select 2 not network");

  // named steps shared by the multi-step checks
  sequence s_cfg_write;
    i_cfg_we && valid_sel;
  endsequence

  sequence s_cfg_bad;
    i_cfg_we && !valid_sel;
  endsequence

  sequence s_sel_lock_off;
    cfg_r.mode_select == doms_pkg::MSEL_LOCK && !lock_on;
  endsequence

  sequence s_lock_stop_ext;
    cfg_r.mode_select == doms_pkg::MSEL_LOCK && lock_on &&
    mode_nxt == 4'h2;
  endsequence

  sequence s_pe_only;
    as_pe && !as_ne && !as_np;
  endsequence

  a_sel_write: assert property (@(posedge i_mclk)
    disable iff (i_rst) s_cfg_write |=>
    cfg_r.mode_select == $past(i_cfg.mode_select))
    else $error("legal select not taken");

  a_sel_refuse: assert property (@(posedge i_mclk)
    disable iff (i_rst) s_cfg_bad |=> $stable(cfg_r.mode_select))
    else $error("illegal select taken");

  a_lock_quiet: assert property (@(posedge i_mclk)
    disable iff (i_rst) s_sel_lock_off |=> !o_output_stop)
    else $error("output stopped with interlock off");

  a_out_stop_ext: assert property (@(posedge i_mclk)
    disable iff (i_rst) s_lock_stop_ext |=> o_output_stop)
    else $error("no output stop in external");

  a_out_stop_plain: assert property (@(posedge i_mclk)
    disable iff (i_rst) cfg_r.mode_select != 3'h7 |=>
    o_output_stop == $past(in_r.output_stop))
    else $error("output stop not plain");

  a_lock_polarity: assert property (@(posedge i_mclk)
    disable iff (i_rst) !as_lock && cfg_r.stop_logic == 2'h2 |->
    lock_on != in_r.output_stop)
    else $error("interlock polarity not inverted");

  a_lock_run_hold: assert property (@(posedge i_mclk)
    disable iff (i_rst) cfg_r.mode_select == 3'h7 && lock_on &&
    !stopped |=> $stable(mode_r))
    else $error("switch while running under interlock");

  a_ext_net_gate: assert property (@(posedge i_mclk)
    disable iff (i_rst) cfg_r.mode_select == 3'h2 && !stopped &&
    cfg_r.startup_mode != 4'ha && mode_r != 4'h4 |=> mode_r != 4'h4)
    else $error("network entered while running");

  a_sel2_no_panel: assert property (@(posedge i_mclk)
    disable iff (i_rst) cfg_r.mode_select == 3'h2 && mode_r != 4'h1 |=>
    mode_r != 4'h1) else $error("panel under select 2");

  a_run_switch6: assert property (@(posedge i_mclk)
    disable iff (i_rst) s_pe_only ##0
    (cfg_r.mode_select == 3'h6 && !in_r.pe_sw) |=> mode_r == 4'h1)
    else $error("select 6 no panel while running");

  a_pe_ext_on: assert property (@(posedge i_mclk)
    disable iff (i_rst) s_pe_only ##0
    (cfg_r.mode_select == 3'h0 && stopped && in_r.pe_sw) |=>
    mode_r == 4'h2) else $error("switch on not external");

  a_np_panel: assert property (@(posedge i_mclk)
    disable iff (i_rst) cfg_r.startup_mode == 4'ha && as_np &&
    in_r.np_sw && !as_ne && run_ok &&
    (cfg_r.mode_select == 3'h0 || cfg_r.mode_select == 3'h6) |=>
    mode_r == 4'h1) else $error("net/panel on not panel");

  a_np_no_ext: assert property (@(posedge i_mclk)
    disable iff (i_rst) cfg_r.startup_mode == 4'ha && as_np &&
    !as_ne && run_ok && mode_r != 4'h2 &&
    (cfg_r.mode_select == 3'h0 || cfg_r.mode_select == 3'h6) |=>
    mode_r != 4'h2) else $error("net/panel gave external");

  a_np_off_panel: assert property (@(posedge i_mclk)
    disable iff (i_rst) cfg_r.startup_mode == 4'ha && as_np &&
    !in_r.np_sw && !as_ne && cfg_r.net_src_zero &&
    !cfg_r.option_fitted && run_ok && cfg_r.mode_select == 3'h0 |=>
    mode_r == 4'h1) else $error("no option not panel");

  a_ne_net: assert property (@(posedge i_mclk)
    disable iff (i_rst) as_ne && in_r.ne_sw && run_ok &&
    (cfg_r.mode_select == 3'h0 || cfg_r.mode_select == 3'h6) |=>
    mode_r == 4'h4) else $error("net/ext on not network");

  a_ne_ext: assert property (@(posedge i_mclk)
    disable iff (i_rst) as_ne && !in_r.ne_sw && !as_np && !as_pe &&
    stopped && cfg_r.mode_select == 3'h0 |=> mode_r == 4'h2)
    else $error("net/ext off not external");

  a_ne_pe_panel: assert property (@(posedge i_mclk)
    disable iff (i_rst) as_ne && !in_r.ne_sw && !as_np && as_pe &&
    !in_r.pe_sw && stopped && cfg_r.mode_select == 3'h0 |=>
    mode_r == 4'h1) else $error("external not refined to panel");

  a_sync_agree: assert property (@(posedge i_mclk)
    disable iff (i_rst) s2_r.pe_sw != s3_r.pe_sw |=> $stable(in_r.pe_sw))
    else $error("pin taken before stages agree");
endmodule

//--- sim/doms_term_model.sv
`timescale 1ns/1ps
module doms_term_model (
  // clock
  input wire logic i_mclk,
  // requested terminal levels
  input wire logic i_stop,
  input wire logic i_pe,
  input wire logic i_run,
  input wire logic i_ne,
  input wire logic i_np,
  // pins toward the selector
  output doms_pkg::doms_in_t o_pins
);
  initial o_pins = 8'h01;
  // levels change on the falling edge, motor at rest only without start
  always @(negedge i_mclk) begin
    o_pins.output_stop <= i_stop;
    o_pins.interlock <= 1'b0;
    o_pins.pe_sw <= i_pe;
    o_pins.fwd <= i_run;
    o_pins.rev <= 1'b0;
    o_pins.np_sw <= i_np;
    o_pins.ne_sw <= i_ne;
    o_pins.at_rest <= !i_run;
  end
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_cfg_we = 1'b0;
  doms_pkg::doms_cfg_t i_cfg = '0;
  logic [6:0] i_term_func [7];
  doms_pkg::doms_in_t i_pins;
  logic [3:0] o_mode_onehot;
  logic [2:0] o_mode_select;
  logic o_output_stop, o_interlock_active;
  logic stop_q = 1'b0, pe_q = 1'b0, run_q = 1'b0, ne_q = 1'b0, np_q = 1'b0;
  logic [15:0] rnd = 16'h1ca4;
  int fail_count = 0, compares = 0;
  doms_term_model u_term (.i_mclk(i_mclk), .i_stop(stop_q), .i_pe(pe_q),
    .i_run(run_q), .i_ne(ne_q), .i_np(np_q), .o_pins(i_pins));
  doms_mode_selector dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_cfg(i_cfg),
    .i_cfg_we(i_cfg_we), .i_term_func(i_term_func), .i_pins(i_pins),
    .o_mode_onehot(o_mode_onehot), .o_output_stop(o_output_stop),
    .o_interlock_active(o_interlock_active), .o_mode_select(o_mode_select));
  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // mode under the panel/external switch, stopped, interlock on
  function automatic logic [3:0] exp_pe(input logic [2:0] sel, input logic pe);
    case (sel)
      3'h1: return 4'h1;
      3'h2: return 4'h2;
      3'h3, 3'h4: return 4'h8;
      default: return pe ? 4'h2 : 4'h1;
    endcase
  endfunction
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic [2:0] sel, input logic [1:0] sl);
    @(negedge i_mclk);
    i_cfg.mode_select = sel;
    i_cfg.stop_logic = sl;
    i_cfg_we = 1'b1;
    @(negedge i_mclk);
    i_cfg_we = 1'b0;
    repeat (10) @(negedge i_mclk);
  endtask
  task automatic pins(input logic s, input logic p, input logic r,
    input logic n);
    stop_q = s;
    pe_q = p;
    run_q = r;
    ne_q = n;
    repeat (12) @(negedge i_mclk);
  endtask
  task automatic stop_test();
    $display("counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    logic [2:0] sels [6];
    sels = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
    foreach (i_term_func[i]) i_term_func[i] = 7'h00;
    repeat (3) @(negedge i_mclk);
    i_rst = 1'b0;
    @(negedge i_mclk);
    chk(o_mode_onehot, 4'h2);
    chk({1'b0, o_mode_select}, 4'h0);
    chk({3'h0, o_output_stop}, 4'h0);
    $display("test reset done");
    i_term_func[rnd % 7] = 7'h10;
    foreach (sels[i]) begin
      cfg(sels[i], 2'h0);
      repeat (3) begin
        rnd = lfsr(rnd);
        pins(1'b0, rnd[0], 1'b0, 1'b0);
        chk(o_mode_onehot, exp_pe(sels[i], rnd[0]));
      end
    end
    $display("test table done");
    cfg(3'h0, 2'h0);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    chk(o_mode_onehot, 4'h1);
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    chk(o_mode_onehot, 4'h2);
    cfg(3'h6, 2'h0);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    chk(o_mode_onehot, 4'h1);
    cfg(3'h5, 2'h0);
    chk({1'b0, o_mode_select}, 4'h6);
    $display("test running done");
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    cfg(3'h7, 2'h0);
    chk(o_mode_onehot, 4'h2);
    chk({3'h0, o_interlock_active}, 4'h1);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    chk(o_mode_onehot, 4'h1);
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    chk(o_mode_onehot, 4'h2);
    chk({3'h0, o_output_stop}, 4'h1);
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    chk(o_mode_onehot, 4'h2);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    chk(o_mode_onehot, 4'h1);
    cfg(3'h7, 2'h2);
    chk(o_mode_onehot, 4'h2);
    $display("test interlock done");
    cfg(3'h2, 2'h0);
    i_term_func[rnd % 7 == 3 ? 4 : rnd % 7] = 7'h42;
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    chk(o_mode_onehot, 4'h4);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    chk(o_mode_onehot, 4'h2);
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    cfg(3'h1, 2'h0);
    chk(o_mode_onehot, 4'h1);
    cfg(3'h0, 2'h0);
    chk(o_mode_onehot, 4'h4);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    chk(o_mode_onehot, 4'h1);
    $display("test network done");
    foreach (i_term_func[i]) i_term_func[i] = 7'h00;
    i_term_func[1] = 7'h41;
    i_term_func[2] = 7'h10;
    i_cfg.startup_mode = 4'ha;
    np_q = 1'b1;
    cfg(3'h2, 2'h0);
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    chk(o_mode_onehot, 4'h4);
    cfg(3'h0, 2'h0);
    chk(o_mode_onehot, 4'h1);
    np_q = 1'b0;
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    chk(o_mode_onehot, 4'h4);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    chk(o_mode_onehot, 4'h1);
    chk({3'h0, o_output_stop}, 4'h1);
    $display("test startup done");
    stop_test();
  end
endmodule
